// *** bench/blc_fabric_model.sv ***
/*
  Behavioural model of the fabric user logic beside the bonded lanes.
  Assumes the bench queues transmit words in q and that the block takes a
  word on a rising edge where valid, the exported tick and ready are all high.
*/
module blc_fabric_model #(
  parameter int W = 32 // word width, all lanes side by side
) (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // synchronous reset, high
  input wire logic core_clk_en_i, // exported common slow tick
  input wire logic tx_ready_i, // phase fifo has space
  output logic [W-1:0] tx_data_o, // words towards the lanes
  output logic tx_valid_o // word offered
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [W-1:0] q[$];

  initial begin
    tx_data_o = '0;
    tx_valid_o = 1'b0;
  end

  // ----------------------------------------------------------------
  // hand-over
  // ----------------------------------------------------------------
  // a word leaves the queue only on an exported tick
  always @(posedge clk_i) begin
    if (!rst_i && tx_valid_o && core_clk_en_i && tx_ready_i) begin
      q.delete(0);
    end
  end

  // launch after the falling edge; idle lines toggle so stale data never looks valid
  always @(negedge clk_i) begin
    if (rst_i || q.size() == 0) begin
      tx_valid_o <= 1'b0;
      tx_data_o <= ~tx_data_o;
    end else begin
      tx_valid_o <= 1'b1;
      tx_data_o <= q[0];
    end
  end
endmodule : blc_fabric_model

// *** bench/blc_top_tb.sv ***
/*
  Self-checking bench of the bonded lane clock distribution block.
  Assumes ticks are one-cycle pulses on CLK_I and that outputs follow a
  tick one edge later; inputs change on the falling edge.
*/
module blc_top_tb;
  import blc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int F_SER = 7;
  localparam int F_TXPCS = 6;
  localparam int F_TXRD = 5;
  localparam int F_DESER = 4;
  localparam int F_ALIGN = 3;
  localparam int F_RXPCS = 2;
  localparam int F_RXWR = 1;
  localparam int F_CLKOUT = 0;

  logic clk = 1'b0;
  logic rst = 1'b1;
  blc_cfg_t cfg = BLC_CFG_RST;
  blc_tick_t pll_a = '0;
  blc_tick_t pll_b = '0;
  blc_tick_t pll_far = '0;
  logic [3:0] hs_sel = '0;
  logic [3:0] rec_hs = '0;
  logic [3:0] rec_ls = '0;
  logic [31:0] tx_data;
  logic tx_valid;
  logic pcs_rdy = 1'b0;
  logic tx_ready;
  logic [31:0] lane_data;
  logic lane_valid;
  blc_lane_clk_t [3:0] lane_clk;
  logic core_en;
  logic [3:0] mask;
  int bad_count = 0;
  int num_checks = 0;
  int cyc = 0;

  always #5 clk = ~clk;

  blc_top uut (
    .CLK_I(clk), .SYS_RST_I(rst), .CFG_I(cfg), .PLL_A_I(pll_a), .PLL_B_I(pll_b),
    .PLL_FAR_I(pll_far), .HS_SEL_I(hs_sel), .REC_HS_I(rec_hs), .REC_LS_I(rec_ls),
    .TX_DATA_I(tx_data), .TX_VALID_I(tx_valid), .PCS_READY_I(pcs_rdy), .TX_READY_O(tx_ready),
    .TX_LANE_DATA_O(lane_data), .TX_LANE_VALID_O(lane_valid), .LANE_CLK_O(lane_clk),
    .CORE_CLK_EN_O(core_en), .BOND_MASK_O(mask)
  );

  blc_fabric_model fab (
    .clk_i(clk), .rst_i(rst), .core_clk_en_i(core_en), .tx_ready_i(tx_ready),
    .tx_data_o(tx_data), .tx_valid_o(tx_valid)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out

  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      close_out();
    end
  end

  task automatic chk_w(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch at %0t: value %h want %h", $time, g, e);
    end
  endtask : chk_w

  // gathers one tick field over the four lanes
  task automatic chk_t(input int b, input logic [3:0] e);
    logic [3:0] g;
    for (int l = 0; l < 4; l++) g[l] = lane_clk[l][b];
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch at %0t: field %0d got %h want %h", $time, b, g, e);
    end
  endtask : chk_t

  task automatic do_reset;
    @(negedge clk);
    rst = 1'b1;
    repeat (20) @(negedge clk);
    rst = 1'b0;
  endtask : do_reset

  task automatic set_cfg(input blc_bond_t bd, input blc_mode_t md, input logic ls, input logic bs,
                         input logic bds, input logic lp, input logic fs, input logic [3:0] h);
    @(negedge clk);
    cfg = '{bd, md, ls, bs, bds, lp, fs};
    hs_sel = h;
    repeat (2) @(negedge clk);
  endtask : set_cfg

  // one-cycle ticks; outputs are settled at the return
  task automatic tick(input logic [1:0] a, input logic [1:0] b, input logic [1:0] f,
                      input logic [3:0] rh, input logic [3:0] rl);
    @(negedge clk);
    pll_a = a;
    pll_b = b;
    pll_far = f;
    rec_hs = rh;
    rec_ls = rl;
    @(negedge clk);
    pll_a = '0;
    pll_b = '0;
    pll_far = '0;
    rec_hs = '0;
    rec_ls = '0;
  endtask : tick

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic sc_x4;
    set_cfg(BLC_BOND_X4, BLC_MODE_TX_ONLY, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 4'h5);
    tick(2'b11, 2'b00, 2'b00, 4'h0, 4'h0);
    chk_w(core_en, 1);
    chk_w(mask, 4'hF);
    chk_t(F_SER, 4'hA);
    chk_t(F_TXPCS, 4'hF);
    chk_t(F_TXRD, 4'hF);
    chk_t(F_RXPCS, 4'h0);
    tick(2'b00, 2'b11, 2'b00, 4'h0, 4'h0);
    chk_w(core_en, 0);
    chk_t(F_SER, 4'h5);
    chk_t(F_TXPCS, 4'h0);
  endtask : sc_x4

  task automatic sc_x2;
    set_cfg(BLC_BOND_X2, BLC_MODE_TX_ONLY, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0);
    tick(2'b01, 2'b00, 2'b00, 4'h0, 4'h0);
    chk_w(core_en, 0);
    chk_t(F_TXPCS, 4'hC);
    tick(2'b00, 2'b01, 2'b00, 4'h0, 4'h0);
    chk_w(core_en, 1);
    chk_w(mask, 4'h3);
    chk_t(F_TXPCS, 4'h3);
  endtask : sc_x2

  task automatic sc_far;
    set_cfg(BLC_BOND_X2, BLC_MODE_TX_ONLY, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 4'h0);
    tick(2'b00, 2'b00, 2'b11, 4'h0, 4'h0);
    chk_w(core_en, 1);
    chk_t(F_SER, 4'h3);
    set_cfg(BLC_BOND_X2, BLC_MODE_TX_ONLY, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 4'h0);
    tick(2'b00, 2'b00, 2'b11, 4'h0, 4'h0);
    chk_w(core_en, 0);
    chk_t(F_SER, 4'h0);
  endtask : sc_far

  task automatic sc_rx_only;
    set_cfg(BLC_BOND_X4, BLC_MODE_RX_ONLY, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0);
    tick(2'b11, 2'b00, 2'b00, 4'h9, 4'h6);
    chk_w(core_en, 0);
    chk_w(mask, 4'h0);
    chk_t(F_CLKOUT, 4'h6);
    chk_t(F_DESER, 4'h9);
  endtask : sc_rx_only

  task automatic sc_rm;
    set_cfg(BLC_BOND_X4, BLC_MODE_TX_RX_RM, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0);
    tick(2'b01, 2'b00, 2'b00, 4'h6, 4'h9);
    chk_w(core_en, 1);
    chk_t(F_DESER, 4'h6);
    chk_t(F_ALIGN, 4'h9);
    chk_t(F_RXPCS, 4'hF);
    chk_t(F_RXWR, 4'hF);
    chk_t(F_CLKOUT, 4'h0);
    tick(2'b00, 2'b00, 2'b00, 4'h0, 4'hF);
    chk_t(F_RXPCS, 4'h0);
    chk_t(F_ALIGN, 4'hF);
  endtask : sc_rm

  task automatic sc_norm;
    set_cfg(BLC_BOND_X4, BLC_MODE_TX_RX_NORM, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0);
    tick(2'b01, 2'b00, 2'b00, 4'h0, 4'h3);
    chk_t(F_TXPCS, 4'hF);
    chk_t(F_RXPCS, 4'h3);
    chk_t(F_RXWR, 4'h3);
    chk_t(F_CLKOUT, 4'h3);
  endtask : sc_norm

  task automatic sc_div;
    do_reset();
    set_cfg(BLC_BOND_X4, BLC_MODE_TX_RX_RM, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 4'h0);
    tick(2'b01, 2'b00, 2'b00, 4'h0, 4'h0);
    chk_t(F_TXPCS, 4'hF);
    chk_t(F_TXRD, 4'h0);
    chk_t(F_RXWR, 4'h0);
    tick(2'b01, 2'b00, 2'b00, 4'h0, 4'h0);
    chk_t(F_TXRD, 4'hF);
    chk_t(F_RXWR, 4'hF);
  endtask : sc_div

  // fill while the coding path stalls, then drain in order
  task automatic sc_fifo;
    int n;
    n = 0;
    pcs_rdy = 1'b0;
    for (int k = 0; k < 18; k++) fab.q.push_back(32'hA0B0C0D0 + k * 32'h01010101);
    @(negedge clk);
    pll_a = 2'b01;
    repeat (24) @(negedge clk);
    chk_w(tx_ready, 0);
    chk_w(fab.q.size(), 2);
    pcs_rdy = 1'b1;
    repeat (60) begin
      @(negedge clk);
      if (lane_valid === 1'b1) begin
        chk_w(lane_data, 32'hA0B0C0D0 + n * 32'h01010101);
        n++;
      end
    end
    chk_w(n, 18);
    chk_w(tx_ready, 1);
    pll_a = '0;
  endtask : sc_fifo

  initial begin
    do_reset();
    sc_x4();
    sc_x2();
    sc_far();
    sc_rx_only();
    sc_rm();
    sc_norm();
    sc_div();
    sc_fifo();
    close_out();
  end
endmodule : blc_top_tb

// *** design/blc_div2.sv ***
/*
  Divide-by-two of a tick stream.
  Assumes the input tick is a one-cycle pulse; the output is combinational
  from the phase flop and the tick, so the caller registers it.
*/
module blc_div2 (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // synchronous reset, high
  input wire logic tick_i, // incoming tick
  output logic half_o // every second tick
);

  logic phase_q;

  // phase restarts on reset so shared dividers stay aligned
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_q <= 1'b0;
    end else if (tick_i) begin
      phase_q <= ~phase_q;
    end
  end

  assign half_o = tick_i & phase_q;

  AST_DIV_HALF: assert property (@(posedge clk_i) disable iff (rst_i)
    half_o |=> !half_o) else $error("divider passed two ticks in a row");

endmodule : blc_div2

// *** design/blc_fifo.sv ***
/*
  Phase compensation FIFO with one pointer set for all bonded lanes.
  Assumes DEPTH is a power of two; the write and read strobes are already
  qualified by the clock ticks of their sides.
*/
module blc_fifo #(
  parameter int W = 32, // total width, all lanes side by side
  parameter int DEPTH = 16 // entries
) (
  input wire logic clk_i, // system clock
  input wire logic rst_i, // synchronous reset, high
  input wire logic in_valid_i, // write request
  output logic in_ready_o, // space left, registered
  input wire logic [W-1:0] in_data_i, // write data
  output logic out_valid_o, // data held
  input wire logic out_ready_i, // read request
  output logic [W-1:0] out_data_o // head word
);

  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  logic [AW:0] count_d;
  logic push;
  logic pop;

  assign push = in_valid_i & in_ready_o;
  assign pop = out_ready_i & out_valid_o;
  assign out_valid_o = (count_q != '0);
  assign out_data_o = mem[rd_ptr_q];
  assign count_d = count_q + (AW+1)'(push) - (AW+1)'(pop);

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data_i;
    end
  end

  // one pointer pair serves every lane, reset as one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
      in_ready_o <= 1'b0;
    end else begin
      wr_ptr_q <= wr_ptr_q + AW'(push);
      rd_ptr_q <= rd_ptr_q + AW'(pop);
      count_q <= count_d;
      in_ready_o <= (count_d != FULL);
    end
  end

  AST_FIFO_RST_ALIGN: assert property (@(posedge clk_i)
    $fell(rst_i) |-> (wr_ptr_q == '0) && (rd_ptr_q == '0) && !out_valid_o) else $error("pointers not aligned after reset");

  AST_FIFO_NO_OVF: assert property (@(posedge clk_i) disable iff (rst_i)
    (count_q == FULL) |-> !in_ready_o) else $error("ready while full");

endmodule : blc_fifo

// *** design/blc_pkg.sv ***
/*
  Shared types and constants of the bonded lane clock distribution block.
  Assumes a single 100 MHz system clock; every transceiver clock is modelled
  as a one-cycle tick (enable pulse) on that clock.
*/
package blc_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int BLC_LANES = 4;
  localparam int BLC_LANE_W = 8;
  localparam int BLC_FIFO_DEPTH = 16;
  localparam int BLC_X2_LANES = 2;
  localparam real BLC_CLK_PERIOD_NS = 10.0;

  // ----------------------------------------------------------------
  // modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BLC_BOND_NONE,
    BLC_BOND_X2,
    BLC_BOND_X4
  } blc_bond_t;

  typedef enum logic [1:0] {
    BLC_MODE_TX_ONLY,
    BLC_MODE_TX_RX_RM,
    BLC_MODE_TX_RX_NORM,
    BLC_MODE_RX_ONLY
  } blc_mode_t;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic hs;
    logic ls;
  } blc_tick_t;

  typedef struct packed {
    blc_bond_t bond;
    blc_mode_t mode;
    logic ls_sel;
    logic byte_ser;
    logic byte_deser;
    logic large_pkg;
    logic far_src;
  } blc_cfg_t;

  typedef struct packed {
    logic ser;
    logic tx_pcs;
    logic tx_fifo_rd;
    logic deser;
    logic rx_align;
    logic rx_pcs;
    logic rx_fifo_wr;
    logic rx_clkout;
  } blc_lane_clk_t;

  localparam blc_cfg_t BLC_CFG_RST = '{BLC_BOND_NONE, BLC_MODE_TX_ONLY, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
  localparam blc_lane_clk_t BLC_LANE_CLK_RST = '0;

endpackage : blc_pkg

// *** design/blc_top.sv ***
/*
  Bonded lane clock distribution: picks fast and slow clock sources per lane,
  forms the common bonded slow clock, exports it to the fabric, and carries
  transmit words through a phase FIFO whose pointers are shared by all lanes.
  Assumes all transceiver clocks arrive as ticks synchronous to CLK_I and
  the fabric launches on the exported core tick.
*/
module blc_top
  import blc_pkg::*;
#(
  parameter int LANES = blc_pkg::BLC_LANES, // lanes in a block
  parameter int LANE_W = blc_pkg::BLC_LANE_W, // data bits per lane
  parameter int DEPTH = blc_pkg::BLC_FIFO_DEPTH // phase FIFO entries
) (
  input wire logic CLK_I, // 100 MHz system clock
  input wire logic SYS_RST_I, // synchronous reset, high
  input wire blc_pkg::blc_cfg_t CFG_I, // bonding and datapath mode
  input wire blc_pkg::blc_tick_t PLL_A_I, // adjacent_pll_a ticks
  input wire blc_pkg::blc_tick_t PLL_B_I, // adjacent_pll_b ticks
  input wire blc_pkg::blc_tick_t PLL_FAR_I, // non-adjacent PLL ticks
  input wire logic [LANES-1:0] HS_SEL_I, // per lane: 1 selects pll b
  input wire logic [LANES-1:0] REC_HS_I, // recovered fast ticks
  input wire logic [LANES-1:0] REC_LS_I, // recovered slow ticks
  input wire logic [LANES*LANE_W-1:0] TX_DATA_I, // fabric words, lane 0 low
  input wire logic TX_VALID_I, // fabric word valid
  input wire logic PCS_READY_I, // tx coding path can accept
  output logic TX_READY_O, // FIFO has space
  output logic [LANES*LANE_W-1:0] TX_LANE_DATA_O, // words to lane coders
  output logic TX_LANE_VALID_O, // one-cycle word strobe
  output blc_pkg::blc_lane_clk_t [LANES-1:0] LANE_CLK_O, // per lane ticks
  output logic CORE_CLK_EN_O, // exported common slow tick
  output logic [LANES-1:0] BOND_MASK_O // lanes in the bonded group
);

  import blc_pkg::*;

  // ----------------------------------------------------------------
  // configuration capture
  // ----------------------------------------------------------------
  blc_cfg_t cfg_q;

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      cfg_q <= BLC_CFG_RST;
    end else begin
      cfg_q <= CFG_I;
    end
  end

  // ----------------------------------------------------------------
  // mode decode
  // ----------------------------------------------------------------
  logic bond_ok;
  logic bond_any;
  logic use_far;
  logic tx_on;
  logic rx_on;
  logic rm_on;
  logic common_ls;
  logic tx_rd_common;
  logic rx_wr_common;
  logic [LANES-1:0] bonded;

  assign bond_ok = (cfg_q.mode != BLC_MODE_RX_ONLY);
  assign bond_any = bond_ok && (cfg_q.bond != BLC_BOND_NONE);
  assign tx_on = (cfg_q.mode != BLC_MODE_RX_ONLY);
  assign rx_on = (cfg_q.mode != BLC_MODE_TX_ONLY);
  assign rm_on = (cfg_q.mode == BLC_MODE_TX_RX_RM);

  // far source only for x2 groups in the larger packages
  assign use_far = cfg_q.far_src && cfg_q.large_pkg && bond_ok && (cfg_q.bond == BLC_BOND_X2);

  // common bonded slow path: one mux for the whole group
  assign common_ls = use_far ? PLL_FAR_I.ls : (cfg_q.ls_sel ? PLL_B_I.ls : PLL_A_I.ls);

  // ----------------------------------------------------------------
  // shared dividers for the bonded group
  // ----------------------------------------------------------------
  logic tx_half_common;
  logic rx_half_common;

  blc_div2 u_tx_div (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .tick_i(common_ls & tx_on),
    .half_o(tx_half_common)
  );

  blc_div2 u_rx_div (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .tick_i(common_ls & rm_on),
    .half_o(rx_half_common)
  );

  assign tx_rd_common = cfg_q.byte_ser ? tx_half_common : (common_ls & tx_on);
  assign rx_wr_common = cfg_q.byte_deser ? rx_half_common : (common_ls & rm_on);

  // ----------------------------------------------------------------
  // per lane clock routing
  // ----------------------------------------------------------------
  blc_lane_clk_t [LANES-1:0] lane_d;

  for (genvar l = 0; l < LANES; l++) begin : g_lane
    logic own_hs;
    logic own_ls;
    logic tx_pcs;
    logic rx_pcs;
    logic tx_half_own;
    logic rx_half_own;

    // x4 takes all lanes, x2 only the low pair
    assign bonded[l] = bond_ok && ((cfg_q.bond == BLC_BOND_X4) ||
                       ((cfg_q.bond == BLC_BOND_X2) && (l < BLC_X2_LANES)));

    // fast clock chosen per lane, except bonded lanes on the far source all take PLL_FAR_I
    assign own_hs = (bonded[l] && use_far) ? PLL_FAR_I.hs :
                    (HS_SEL_I[l] ? PLL_B_I.hs : PLL_A_I.hs);
    assign own_ls = HS_SEL_I[l] ? PLL_B_I.ls : PLL_A_I.ls;

    assign tx_pcs = tx_on && (bonded[l] ? common_ls : own_ls);
    assign rx_pcs = rx_on && ((rm_on && bonded[l]) ? common_ls :
                              (rm_on ? own_ls : REC_LS_I[l]));

    // unbonded lanes keep their own divider phase
    blc_div2 u_tx_own (
      .clk_i(CLK_I),
      .rst_i(SYS_RST_I),
      .tick_i(tx_pcs),
      .half_o(tx_half_own)
    );

    blc_div2 u_rx_own (
      .clk_i(CLK_I),
      .rst_i(SYS_RST_I),
      .tick_i(rx_pcs),
      .half_o(rx_half_own)
    );

    always_comb begin
      lane_d[l] = BLC_LANE_CLK_RST;
      lane_d[l].ser = tx_on && own_hs;
      lane_d[l].tx_pcs = tx_pcs;
      lane_d[l].tx_fifo_rd = bonded[l] ? tx_rd_common :
                             (cfg_q.byte_ser ? tx_half_own : tx_pcs);
      lane_d[l].deser = rx_on && REC_HS_I[l];
      lane_d[l].rx_align = rx_on && REC_LS_I[l];
      lane_d[l].rx_pcs = rx_pcs;
      lane_d[l].rx_fifo_wr = (rm_on && bonded[l]) ? rx_wr_common :
                             (cfg_q.byte_deser ? rx_half_own : rx_pcs);
      lane_d[l].rx_clkout = rx_on && !rm_on && REC_LS_I[l];
    end
  end

  // ----------------------------------------------------------------
  // registered clock outputs
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      LANE_CLK_O <= '0;
    end else begin
      LANE_CLK_O <= lane_d;
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      CORE_CLK_EN_O <= 1'b0;
      BOND_MASK_O <= '0;
    end else begin
      CORE_CLK_EN_O <= bond_any && common_ls;
      BOND_MASK_O <= bonded;
    end
  end

  // ----------------------------------------------------------------
  // shared transmit phase FIFO
  // ----------------------------------------------------------------
  logic fifo_valid;
  logic fifo_pop;
  logic push_req;
  logic [LANES*LANE_W-1:0] fifo_data;

  // fabric launches on the exported tick, so writes follow it
  assign push_req = TX_VALID_I && CORE_CLK_EN_O;
  // one read strobe drains every bonded lane at once
  assign fifo_pop = bond_any && tx_rd_common && PCS_READY_I;

  blc_fifo #(
    .W(LANES*LANE_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .clk_i(CLK_I),
    .rst_i(SYS_RST_I),
    .in_valid_i(push_req),
    .in_ready_o(TX_READY_O),
    .in_data_i(TX_DATA_I),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_data)
  );

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      TX_LANE_VALID_O <= 1'b0;
      TX_LANE_DATA_O <= '0;
    end else begin
      TX_LANE_VALID_O <= fifo_pop && fifo_valid;
      if (fifo_pop && fifo_valid) begin
        TX_LANE_DATA_O <= fifo_data;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);

  AST_SHARED_READ: assert property (
    BOND_MASK_O[0] && BOND_MASK_O[1] |-> LANE_CLK_O[0].tx_fifo_rd == LANE_CLK_O[1].tx_fifo_rd)
    else $error("bonded lanes read their FIFO at different ticks");

  AST_LANE0_SER_SRC: assert property (
    !$past(use_far) && $past(tx_on) |->
      LANE_CLK_O[0].ser == $past(HS_SEL_I[0] ? PLL_B_I.hs : PLL_A_I.hs))
    else $error("lane 0 fast clock from wrong PLL");

  AST_CORE_FROM_COMMON: assert property (
    ##1 CORE_CLK_EN_O == ($past(bond_any) && $past(common_ls)))
    else $error("exported clock not the common bonded tick");

  AST_X2_FREE_LANES: assert property (
    cfg_q.bond == BLC_BOND_X2 |=> !BOND_MASK_O[2] && !BOND_MASK_O[3])
    else $error("x2 group grabbed lane 2 or 3");

  AST_FAR_ONLY_LARGE: assert property (
    use_far |-> cfg_q.large_pkg && cfg_q.bond == BLC_BOND_X2)
    else $error("far PLL used outside large x2");

  AST_BONDED_TX_PCS: assert property (
    BOND_MASK_O[0] && LANE_CLK_O[0].tx_pcs |-> CORE_CLK_EN_O)
    else $error("bonded encoder tick not common");

  AST_TX_HALF: assert property (
    LANE_CLK_O[0].tx_fifo_rd && cfg_q.byte_ser && $stable(cfg_q) |-> LANE_CLK_O[0].tx_pcs)
    else $error("tx FIFO read off the slow tick");

  AST_NO_RX_BOND: assert property (
    cfg_q.mode == BLC_MODE_RX_ONLY |=> BOND_MASK_O == '0 && !CORE_CLK_EN_O)
    else $error("receive-only lanes bonded");

  AST_RM_RX_PCS: assert property (
    $past(rm_on) && BOND_MASK_O[0] && $stable(cfg_q) |-> LANE_CLK_O[0].rx_pcs == CORE_CLK_EN_O)
    else $error("bonded rx path not on common clock");

  AST_RX_CLKOUT: assert property (
    $past(rx_on) && !$past(rm_on) |-> LANE_CLK_O[1].rx_clkout == $past(REC_LS_I[1]))
    else $error("recovered clock not exported without rate match");

  AST_DESER_REC: assert property (
    LANE_CLK_O[2].deser |-> $past(REC_HS_I[2]))
    else $error("deserializer tick without recovered clock");

endmodule : blc_top
